//--- logic/mfp_port_group.sv
// Summary of operation
// - reset loads port 3 latch with ones
// - port 3 latch and pins separately addressed
// - reset: port 4 latch ones, type zeros
// - port 4 type: zero open-drain, one push-pull
// - port 4 carries serial2 and uart2 pins
// - port 4 pin register read-only live levels
// - port 5 five bits, shared with i2c
// - reset sets port 5 latch ones
// - port 5 upper three read bits zero
// - reset: port 6 inputs, enables ones
// - port 6 direction selects input or output
// - port 6 read: zero, pin, or latch
// - analog select and stop gate port 6
// - bit operation reloads enabled non-analog input bits from pins, other input bits with zero
`timescale 1ns/1ps
module mfp_port_group
  import mfp_pkg::*;
(
  input  wire logic                  mclk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [MFP_AW-1:0]     paddr_i,
  input  wire logic [MFP_DW-1:0]     pwdata_i,
  output logic      [MFP_DW-1:0]     prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  input  wire logic [7:0]            p3_pin_i,
  output logic      [7:0]            p3_pin_o,
  output logic      [7:0]            p3_pin_oe_o,
  input  wire logic [7:0]            p4_pin_i,
  output logic      [7:0]            p4_pin_o,
  output logic      [7:0]            p4_pin_oe_o,
  input  wire logic [MFP_P5_W-1:0]   p5_pin_i,
  output logic      [MFP_P5_W-1:0]   p5_pin_o,
  output logic      [MFP_P5_W-1:0]   p5_pin_oe_o,
  input  wire logic [7:0]            p6_pin_i,
  output logic      [7:0]            p6_pin_o,
  output logic      [7:0]            p6_pin_oe_o,
  input  wire logic                  serial2_clock_out_i,
  input  wire logic                  serial2_data_out_i,
  input  wire logic                  uart2_transmit_i,
  output logic                       serial2_clock_pin_o,
  output logic                       serial2_in_pin_o,
  output logic                       uart2_receive_pin_o,
  input  wire logic [MFP_P5_W-1:0]   i2c_pull_low_i,
  output logic      [MFP_P5_W-1:0]   i2c_pin_o,
  input  wire logic [7:0]            analog_channel_select_i,
  output logic      [MFP_WAKE_W-1:0] wakeup_o,
  output logic                       stop_mode_o
);

  logic [7:0]            p3_latch_q, p3_latch_d;
  logic [7:0]            p4_latch_q, p4_latch_d;
  logic [MFP_P5_W-1:0]   p5_latch_q, p5_latch_d;
  logic [7:0]            p6_latch_q, p6_latch_d;
  logic [7:0]            p4_type_q,  p4_type_d;
  logic [7:0]            p6_dir_q,   p6_dir_d;
  logic [7:0]            p6_inen_q,  p6_inen_d;
  logic [MFP_WAKE_W-1:0] wake_sel_q, wake_sel_d;
  logic [7:0]            sysctl_q,   sysctl_d;

  logic                  wr_en;
  logic                  access;
  logic                  mapped;
  logic [7:0]            p6_read;
  logic [7:0]            p4_periph;
  logic                  bitop_val;
  logic [2:0]            bitop_pos;

  // apb slave: zero wait states
  assign pready_o = 1'b1;
  assign access   = psel_i & penable_i;
  assign wr_en    = access & pwrite_i & pready_o;

  // address decode
  always_comb begin
    mapped = 1'b1;
    if (mfp_hit(paddr_i, IDX_P3_LATCH)) begin
      prdata_o = {24'h000000, p3_latch_q};
    end else if (mfp_hit(paddr_i, IDX_P3_PINS)) begin
      prdata_o = {24'h000000, p3_pin_i};
    end else if (mfp_hit(paddr_i, IDX_P4_LATCH)) begin
      prdata_o = {24'h000000, p4_latch_q};
    end else if (mfp_hit(paddr_i, IDX_P4_PINS)) begin
      prdata_o = {24'h000000, p4_pin_i};
    end else if (mfp_hit(paddr_i, IDX_P4_TYPE)) begin
      prdata_o = {24'h000000, p4_type_q};
    end else if (mfp_hit(paddr_i, IDX_P5_LATCH)) begin
      prdata_o = {27'h0, p5_latch_q};
    end else if (mfp_hit(paddr_i, IDX_P5_PINS)) begin
      prdata_o = {27'h0, p5_pin_i};
    end else if (mfp_hit(paddr_i, IDX_P6_LATCH)) begin
      prdata_o = {24'h000000, p6_read};
    end else if (mfp_hit(paddr_i, IDX_P6_DIR)) begin
      prdata_o = {24'h000000, p6_dir_q};
    end else if (mfp_hit(paddr_i, IDX_P6_INEN)) begin
      prdata_o = {24'h000000, p6_inen_q};
    end else if (mfp_hit(paddr_i, IDX_WAKE_SEL)) begin
      prdata_o = {28'h0000000, wake_sel_q};
    end else if (mfp_hit(paddr_i, IDX_SYSCTL1)) begin
      prdata_o = {24'h000000, sysctl_q};
    end else if (mfp_hit(paddr_i, IDX_P6_BITOP)) begin
      prdata_o = 32'h00000000;
    end else begin
      prdata_o = 32'h00000000;
      mapped   = 1'b0;
    end
  end

  assign pslverr_o = access & ~mapped;

  // bit operation fields
  assign bitop_val = pwdata_i[BITOP_VAL_BIT];
  assign bitop_pos = pwdata_i[BITOP_POS_MSB:BITOP_POS_LSB];

  // register next values
  always_comb begin
    p3_latch_d = p3_latch_q;
    p4_latch_d = p4_latch_q;
    p5_latch_d = p5_latch_q;
    p6_latch_d = p6_latch_q;
    p4_type_d  = p4_type_q;
    p6_dir_d   = p6_dir_q;
    p6_inen_d  = p6_inen_q;
    wake_sel_d = wake_sel_q;
    sysctl_d   = sysctl_q;
    if (wr_en) begin
      if (mfp_hit(paddr_i, IDX_P3_LATCH)) begin
        p3_latch_d = pwdata_i[7:0];
      end else if (mfp_hit(paddr_i, IDX_P4_LATCH)) begin
        p4_latch_d = pwdata_i[7:0];
      end else if (mfp_hit(paddr_i, IDX_P4_TYPE)) begin
        p4_type_d = pwdata_i[7:0];
      end else if (mfp_hit(paddr_i, IDX_P5_LATCH)) begin
        p5_latch_d = pwdata_i[MFP_P5_W-1:0];
      end else if (mfp_hit(paddr_i, IDX_P6_LATCH)) begin
        p6_latch_d = pwdata_i[7:0];
      end else if (mfp_hit(paddr_i, IDX_P6_DIR)) begin
        p6_dir_d = pwdata_i[7:0];
      end else if (mfp_hit(paddr_i, IDX_P6_INEN)) begin
        p6_inen_d = pwdata_i[7:0];
      end else if (mfp_hit(paddr_i, IDX_WAKE_SEL)) begin
        wake_sel_d = pwdata_i[MFP_WAKE_W-1:0];
      end else if (mfp_hit(paddr_i, IDX_SYSCTL1)) begin
        sysctl_d = pwdata_i[7:0];
      end else if (mfp_hit(paddr_i, IDX_P6_BITOP)) begin
        // read-modify-write from the read view: enabled non-analog input bits take pins, other input bits zero
        p6_latch_d = p6_read;
        p6_latch_d[bitop_pos] = bitop_val;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      p3_latch_q <= RST_P3_LATCH;
      p4_latch_q <= RST_P4_LATCH;
      p4_type_q  <= RST_P4_TYPE;
      p5_latch_q <= RST_P5_LATCH;
      p6_latch_q <= RST_P6_LATCH;
      p6_dir_q   <= RST_P6_DIR;
      p6_inen_q  <= RST_P6_INEN;
      wake_sel_q <= RST_WAKE_SEL;
      sysctl_q   <= RST_SYSCTL1;
    end else begin
      p3_latch_q <= p3_latch_d;
      p4_latch_q <= p4_latch_d;
      p4_type_q  <= p4_type_d;
      p5_latch_q <= p5_latch_d;
      p6_latch_q <= p6_latch_d;
      p6_dir_q   <= p6_dir_d;
      p6_inen_q  <= p6_inen_d;
      wake_sel_q <= wake_sel_d;
      sysctl_q   <= sysctl_d;
    end
  end

  // port 3: sink-only, latch one releases the pin
  assign p3_pin_o    = 8'h00;
  assign p3_pin_oe_o = ~p3_latch_q;

  // port 5: sink-only, shared with i2c pull-down
  assign p5_pin_o    = {MFP_P5_W{1'b0}};
  assign p5_pin_oe_o = ~p5_latch_q | i2c_pull_low_i;
  assign i2c_pin_o   = p5_pin_i;

  // port 4 peripheral mux
  always_comb begin
    p4_periph              = 8'hff;
    p4_periph[P4_SCK_BIT]  = serial2_clock_out_i;
    p4_periph[P4_SO_BIT]   = serial2_data_out_i;
    p4_periph[P4_TX_BIT]   = uart2_transmit_i;
  end

  assign serial2_clock_pin_o = p4_pin_i[P4_SCK_BIT];
  assign serial2_in_pin_o    = p4_pin_i[P4_SI_BIT];
  assign uart2_receive_pin_o = p4_pin_i[P4_RX_BIT];

  mfp_p4_driver #(
    .W (8)
  ) u_p4_driver (
    .latch_i      (p4_latch_q),
    .push_pull_i  (p4_type_q),
    .periph_out_i (p4_periph),
    .pin_o        (p4_pin_o),
    .pin_oe_o     (p4_pin_oe_o)
  );

  mfp_p6_cell #(
    .W (8)
  ) u_p6_cell (
    .latch_i      (p6_latch_q),
    .dir_i        (p6_dir_q),
    .inen_i       (p6_inen_q),
    .analog_sel_i (analog_channel_select_i),
    .stop_i       (sysctl_q[SYS_STOP_BIT]),
    .pin_i        (p6_pin_i),
    .pin_o        (p6_pin_o),
    .pin_oe_o     (p6_pin_oe_o),
    .read_o       (p6_read)
  );

  // key-on wakeup only on the upper four pins
  assign wakeup_o    = wake_sel_q & p6_pin_i[7:P6_WAKE_LSB];
  assign stop_mode_o = sysctl_q[SYS_STOP_BIT];

  // checks
  property p_p3_reset;
    @(posedge mclk_i) $rose(rstn_i) |-> p3_latch_q == RST_P3_LATCH && p3_pin_oe_o == 8'h00;
  endproperty
  a_p3_reset: assert property (p_p3_reset) else $error("port 3 latch not ones after reset");

  property p_p4_reset;
    @(posedge mclk_i) $rose(rstn_i) |-> p4_latch_q == RST_P4_LATCH && p4_type_q == RST_P4_TYPE;
  endproperty
  a_p4_reset: assert property (p_p4_reset) else $error("port 4 reset values wrong");

  property p_p6_reset;
    @(posedge mclk_i) $rose(rstn_i) |->
      p6_dir_q == RST_P6_DIR && p6_inen_q == RST_P6_INEN && p6_pin_oe_o == 8'h00;
  endproperty
  a_p6_reset: assert property (p_p6_reset) else $error("port 6 not input after reset");

  property p_p5_reset;
    @(posedge mclk_i) $rose(rstn_i) |-> p5_latch_q == RST_P5_LATCH;
  endproperty
  a_p5_reset: assert property (p_p5_reset) else $error("port 5 latch not ones after reset");

  property p_p3_pins_read;
    @(posedge mclk_i) disable iff (!rstn_i)
      access && !pwrite_i && mfp_hit(paddr_i, IDX_P3_PINS) |-> prdata_o[7:0] == p3_pin_i;
  endproperty
  a_p3_pins_read: assert property (p_p3_pins_read) else $error("port 3 pin read wrong");

  property p_p4_drive;
    @(posedge mclk_i) disable iff (!rstn_i)
      !p4_type_q[0] && p4_latch_q[0] |-> !p4_pin_oe_o[0];
  endproperty
  a_p4_drive: assert property (p_p4_drive) else $error("open-drain pin driven high");

  property p_p4_pins_ro;
    @(posedge mclk_i) disable iff (!rstn_i)
      wr_en && mfp_hit(paddr_i, IDX_P4_PINS) |=> $stable(p4_latch_q) && $stable(p4_type_q);
  endproperty
  a_p4_pins_ro: assert property (p_p4_pins_ro) else $error("pin register write had effect");

  property p_p6_read;
    @(posedge mclk_i) disable iff (!rstn_i)
      !p6_dir_q[0] && !p6_inen_q[0] |-> !p6_read[0];
  endproperty
  a_p6_read: assert property (p_p6_read) else $error("port 6 read not zero");

  property p_p6_stop;
    @(posedge mclk_i) disable iff (!rstn_i)
      sysctl_q[SYS_STOP_BIT] |-> p6_pin_oe_o == 8'h00;
  endproperty
  a_p6_stop: assert property (p_p6_stop) else $error("port 6 driven in stop mode");

  property p_p4_write;
    @(posedge mclk_i) disable iff (!rstn_i)
      wr_en && mfp_hit(paddr_i, IDX_P4_LATCH) |=> p4_latch_q == $past(pwdata_i[7:0]);
  endproperty
  a_p4_write: assert property (p_p4_write) else $error("port 4 latch write lost");

  property p_p6_dir_out;
    @(posedge mclk_i) disable iff (!rstn_i)
      wr_en && mfp_hit(paddr_i, IDX_P6_DIR) && pwdata_i[0] && !analog_channel_select_i[0]
      && !sysctl_q[SYS_STOP_BIT] ##1 !analog_channel_select_i[0] |-> p6_pin_oe_o[0];
  endproperty
  a_p6_dir_out: assert property (p_p6_dir_out) else $error("port 6 output not enabled");

  property p_bitop;
    @(posedge mclk_i) disable iff (!rstn_i)
      wr_en && mfp_hit(paddr_i, IDX_P6_BITOP) && bitop_pos != 3'd1 && !p6_dir_q[1]
      && p6_inen_q[1] && !analog_channel_select_i[1] |=> p6_latch_q[1] == $past(p6_pin_i[1]);
  endproperty
  a_bitop: assert property (p_bitop) else $error("bit operation did not reload pin");

endmodule // mfp_port_group

//--- logic/mfp_pkg.sv
package mfp_pkg;

  localparam int          MFP_AW        = 16;
  localparam int          MFP_DW        = 32;
  localparam int          MFP_IW        = 14;
  localparam int          MFP_P5_W      = 5;
  localparam int          MFP_WAKE_W    = 4;

  // register indices, byte address is four times the index
  localparam logic [13:0] IDX_P3_LATCH  = 14'h0003;
  localparam logic [13:0] IDX_P4_LATCH  = 14'h0004;
  localparam logic [13:0] IDX_P5_LATCH  = 14'h0005;
  localparam logic [13:0] IDX_P6_LATCH  = 14'h0006;
  localparam logic [13:0] IDX_P4_TYPE   = 14'h000a;
  localparam logic [13:0] IDX_P3_PINS   = 14'h000d;
  localparam logic [13:0] IDX_P4_PINS   = 14'h000e;
  localparam logic [13:0] IDX_P5_PINS   = 14'h000f;
  localparam logic [13:0] IDX_P6_DIR    = 14'h0f9b;
  localparam logic [13:0] IDX_P6_INEN   = 14'h0f9c;
  localparam logic [13:0] IDX_WAKE_SEL  = 14'h0fa0;
  localparam logic [13:0] IDX_SYSCTL1   = 14'h0fa1;
  localparam logic [13:0] IDX_P6_BITOP  = 14'h0fa3;

  // reset values
  localparam logic [7:0]  RST_P3_LATCH  = 8'hff;
  localparam logic [7:0]  RST_P4_LATCH  = 8'hff;
  localparam logic [4:0]  RST_P5_LATCH  = 5'h1f;
  localparam logic [7:0]  RST_P6_LATCH  = 8'h00;
  localparam logic [7:0]  RST_P4_TYPE   = 8'h00;
  localparam logic [7:0]  RST_P6_DIR    = 8'h00;
  localparam logic [7:0]  RST_P6_INEN   = 8'hff;
  localparam logic [3:0]  RST_WAKE_SEL  = 4'h0;
  localparam logic [7:0]  RST_SYSCTL1   = 8'h00;

  // field positions
  localparam int          SYS_STOP_BIT  = 7;
  localparam int          P4_SCK_BIT    = 6;
  localparam int          P4_SO_BIT     = 5;
  localparam int          P4_SI_BIT     = 4;
  localparam int          P4_TX_BIT     = 2;
  localparam int          P4_RX_BIT     = 1;
  localparam int          P6_WAKE_LSB   = 4;
  localparam int          BITOP_VAL_BIT = 3;
  localparam int          BITOP_POS_MSB = 2;
  localparam int          BITOP_POS_LSB = 0;

  function automatic logic mfp_hit(input logic [15:0] addr, input logic [13:0] idx);
    return addr == {idx, 2'b00};
  endfunction

endpackage

//--- logic/mfp_p4_driver.sv
`timescale 1ns/1ps
module mfp_p4_driver
  import mfp_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic [W-1:0] latch_i,
  input  wire logic [W-1:0] push_pull_i,
  input  wire logic [W-1:0] periph_out_i,
  output logic      [W-1:0] pin_o,
  output logic      [W-1:0] pin_oe_o
);

  logic [W-1:0] level;

  // peripheral idles high, latch high hands the pin to it
  assign level = latch_i & periph_out_i;

  // zero: sink-only, one: push-pull
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pin_o[i]    = level[i];
      pin_oe_o[i] = push_pull_i[i] | ~level[i];
    end
  end

endmodule // mfp_p4_driver

//--- logic/mfp_p6_cell.sv
`timescale 1ns/1ps
module mfp_p6_cell
  import mfp_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic [W-1:0] latch_i,
  input  wire logic [W-1:0] dir_i,
  input  wire logic [W-1:0] inen_i,
  input  wire logic [W-1:0] analog_sel_i,
  input  wire logic         stop_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] pin_o,
  output logic      [W-1:0] pin_oe_o,
  output logic      [W-1:0] read_o
);

  always_comb begin
    for (int i = 0; i < W; i++) begin
      pin_o[i]    = latch_i[i];
      pin_oe_o[i] = dir_i[i] & ~analog_sel_i[i] & ~stop_i;
      if (dir_i[i]) begin
        read_o[i] = latch_i[i];
      end else if (inen_i[i] & ~analog_sel_i[i]) begin
        read_o[i] = pin_i[i];
      end else begin
        read_o[i] = 1'b0;
      end
    end
  end

endmodule // mfp_p6_cell

//--- bench/mfp_pin_model.sv
`timescale 1ns/1ps
module mfp_pin_model
#(
  parameter int W = 8
) (
  input  wire logic [W-1:0] o_i,
  input  wire logic [W-1:0] oe_i,
  input  wire logic [W-1:0] ext_i,
  output logic      [W-1:0] lvl_o
);
  // driven bits show the device value, released bits the outside level
  // ext carries the pull-up or outside driver, the shared bus wiring
  assign lvl_o = (oe_i & o_i) | (~oe_i & ext_i);
endmodule // mfp_pin_model

//--- bench/mfp_port_group_tb_top.sv
`timescale 1ns/1ps
module mfp_port_group_tb_top
  import mfp_pkg::*;
;
  logic                mclk_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [MFP_AW-1:0]   paddr_i;
  logic [MFP_DW-1:0]   pwdata_i, prdata_o;
  logic [7:0]          p3_pin_i, p3_pin_o, p3_pin_oe_o, p3_ext, p4_pin_i, p4_pin_o;
  logic [7:0]          p4_pin_oe_o, p4_ext, p6_pin_i, p6_pin_o, p6_pin_oe_o, p6_ext;
  logic [7:0]          analog_channel_select_i;
  logic [MFP_P5_W-1:0] p5_pin_i, p5_pin_o, p5_pin_oe_o, p5_ext, i2c_pull_low_i, i2c_pin_o;
  logic                serial2_clock_out_i, serial2_data_out_i, uart2_transmit_i, stop_mode_o;
  logic                serial2_clock_pin_o, serial2_in_pin_o, uart2_receive_pin_o, pin_req;
  logic [3:0]          wakeup_o, pin_sel;
  logic [31:0]         obs;
  logic [32:0]         rd_q[$];
  logic [31:0]         pin_q[$];
  int                  bad_count, num_checks, cyc;

  mfp_port_group u_mfp_port_group (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .p3_pin_i(p3_pin_i), .p3_pin_o(p3_pin_o),
    .p3_pin_oe_o(p3_pin_oe_o), .p4_pin_i(p4_pin_i), .p4_pin_o(p4_pin_o),
    .p4_pin_oe_o(p4_pin_oe_o), .p5_pin_i(p5_pin_i), .p5_pin_o(p5_pin_o),
    .p5_pin_oe_o(p5_pin_oe_o), .p6_pin_i(p6_pin_i), .p6_pin_o(p6_pin_o),
    .p6_pin_oe_o(p6_pin_oe_o), .serial2_clock_out_i(serial2_clock_out_i),
    .serial2_data_out_i(serial2_data_out_i), .uart2_transmit_i(uart2_transmit_i),
    .serial2_clock_pin_o(serial2_clock_pin_o), .serial2_in_pin_o(serial2_in_pin_o),
    .uart2_receive_pin_o(uart2_receive_pin_o), .i2c_pull_low_i(i2c_pull_low_i),
    .i2c_pin_o(i2c_pin_o), .analog_channel_select_i(analog_channel_select_i),
    .wakeup_o(wakeup_o), .stop_mode_o(stop_mode_o));

  mfp_pin_model #(.W(8)) u_mfp_pin_model_p3 (.o_i(p3_pin_o), .oe_i(p3_pin_oe_o),
    .ext_i(p3_ext), .lvl_o(p3_pin_i));
  mfp_pin_model #(.W(8)) u_mfp_pin_model_p4 (.o_i(p4_pin_o), .oe_i(p4_pin_oe_o),
    .ext_i(p4_ext), .lvl_o(p4_pin_i));
  mfp_pin_model #(.W(MFP_P5_W)) u_mfp_pin_model_p5 (.o_i(p5_pin_o), .oe_i(p5_pin_oe_o),
    .ext_i(p5_ext), .lvl_o(p5_pin_i));
  mfp_pin_model #(.W(8)) u_mfp_pin_model_p6 (.o_i(p6_pin_o), .oe_i(p6_pin_oe_o),
    .ext_i(p6_ext), .lvl_o(p6_pin_i));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // output picked for a pin observation
  always_comb begin
    case (pin_sel)
      4'h0: obs = {24'h0, p3_pin_oe_o};
      4'h1: obs = {24'h0, p4_pin_o};
      4'h2: obs = {24'h0, p4_pin_oe_o};
      4'h3: obs = {27'h0, p5_pin_oe_o};
      4'h4: obs = {24'h0, p6_pin_o};
      4'h5: obs = {24'h0, p6_pin_oe_o};
      4'h6: obs = {28'h0, wakeup_o};
      4'h7: obs = {31'h0, stop_mode_o};
      4'h8: obs = {29'h0, serial2_clock_pin_o, serial2_in_pin_o, uart2_receive_pin_o};
      default: obs = {27'h0, i2c_pin_o};
    endcase
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // watcher: oldest note against each result that appears
  always @(posedge mclk_i) begin
    if (psel_i === 1'b1 && penable_i === 1'b1 && pready_o === 1'b1 && pwrite_i === 1'b0
        && rd_q.size() > 0) begin
      cmp({pslverr_o, prdata_o}, rd_q.pop_front());
    end
    if (pin_req === 1'b1 && pin_q.size() > 0) begin
      cmp({1'b0, obs}, {1'b0, pin_q.pop_front()});
    end
  end

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] wd,
                     input logic [32:0] exp);
    @(posedge mclk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= {idx, 2'b00};
    pwdata_i  <= wd;
    if (!wr) rd_q.push_back(exp);
    @(posedge mclk_i);
    penable_i <= 1'b1;
    @(posedge mclk_i);
    while (pready_o !== 1'b1) @(posedge mclk_i);
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h0, d}, 33'h0);
  endtask

  task automatic rd(input logic [13:0] idx, input logic [7:0] d);
    apb(1'b0, idx, 32'h0, {25'h0, d});
  endtask

  task automatic pchk(input logic [3:0] sel, input logic [7:0] exp);
    @(posedge mclk_i);
    pin_sel <= sel;
    pin_req <= 1'b1;
    pin_q.push_back({24'h0, exp});
    @(posedge mclk_i);
    pin_req <= 1'b0;
  endtask

  initial begin : main
    logic [7:0]  a, b, c, d, e, v;
    int unsigned seed;
    seed = $urandom(91014);
    {rstn_i, psel_i, penable_i, pwrite_i, pin_req, pin_sel} = '0;
    {paddr_i, pwdata_i, analog_channel_select_i, i2c_pull_low_i} = '0;
    {p3_ext, p4_ext, p5_ext, p6_ext} = '1;
    {serial2_clock_out_i, serial2_data_out_i, uart2_transmit_i} = 3'b111;
    repeat (6) @(posedge mclk_i);
    rstn_i <= 1'b1;
    rd(IDX_P3_LATCH, 8'hff);
    rd(IDX_P4_LATCH, 8'hff);
    rd(IDX_P4_TYPE, 8'h00);
    rd(IDX_P5_LATCH, 8'h1f);
    rd(IDX_P6_LATCH, 8'hff);
    pchk(4'h4, 8'h00);
    rd(IDX_P6_DIR, 8'h00);
    rd(IDX_P6_INEN, 8'hff);
    pchk(4'h5, 8'h00);
    pchk(4'h0, 8'h00);
    for (int i = 0; i < 4; i++) begin
      a = 8'($urandom);
      e = 8'($urandom);
      p3_ext <= e;
      wr(IDX_P3_LATCH, a);
      rd(IDX_P3_LATCH, a);
      rd(IDX_P3_PINS, a & e);
      pchk(4'h0, ~a);
    end
    for (int i = 0; i < 4; i++) begin
      a = 8'($urandom);
      b = 8'($urandom);
      c = 8'($urandom);
      d = 8'($urandom);
      p4_ext <= c;
      {serial2_clock_out_i, serial2_data_out_i, uart2_transmit_i} <= d[2:0];
      wr(IDX_P4_LATCH, a);
      wr(IDX_P4_TYPE, b);
      v = a & {1'b1, d[2], d[1], 2'b11, d[0], 2'b11};
      e = ((b | ~v) & v) | (~(b | ~v) & c);
      pchk(4'h1, v);
      pchk(4'h2, b | ~v);
      wr(IDX_P4_PINS, ~e);
      rd(IDX_P4_PINS, e);
      pchk(4'h8, {5'h0, e[6], e[4], e[1]});
    end
    for (int i = 0; i < 4; i++) begin
      a = {3'h0, 5'($urandom)};
      b = {3'h0, 5'($urandom)};
      c = {3'h0, 5'($urandom)};
      p5_ext <= c[4:0];
      i2c_pull_low_i <= b[4:0];
      wr(IDX_P5_LATCH, a);
      rd(IDX_P5_LATCH, a);
      pchk(4'h3, (~a | b) & 8'h1f);
      rd(IDX_P5_PINS, c & a & ~b);
      pchk(4'h9, c & a & ~b);
    end
    for (int i = 0; i < 6; i++) begin
      a = 8'($urandom);
      b = 8'($urandom);
      c = 8'($urandom);
      d = 8'($urandom);
      e = (i < 3) ? 8'h00 : 8'($urandom);
      b = b & ~e;
      c = c & ~e;
      p6_ext <= d;
      wr(IDX_P6_LATCH, a);
      wr(IDX_P6_DIR, b);
      wr(IDX_P6_INEN, c);
      analog_channel_select_i <= e;
      rd(IDX_P6_LATCH, (b & a) | (~b & c & d));
      pchk(4'h4, a);
      pchk(4'h5, b);
      analog_channel_select_i <= 8'h00;
    end
    wr(IDX_P6_DIR, 8'hff);
    wr(IDX_SYSCTL1, 8'h80);
    pchk(4'h7, 8'h01);
    pchk(4'h5, 8'h00);
    wr(IDX_SYSCTL1, 8'h00);
    pchk(4'h5, 8'hff);
    analog_channel_select_i <= 8'h3c;
    pchk(4'h5, 8'hc3);
    analog_channel_select_i <= 8'h00;
    wr(IDX_P6_DIR, 8'h00);
    for (int i = 0; i < 3; i++) begin
      a = 8'($urandom);
      d = 8'($urandom);
      p6_ext <= d;
      wr(IDX_WAKE_SEL, a);
      rd(IDX_WAKE_SEL, {4'h0, a[3:0]});
      pchk(4'h6, {4'h0, a[3:0] & d[7:4]});
    end
    for (int i = 0; i < 4; i++) begin
      a = 8'($urandom);
      b = 8'($urandom);
      c = 8'($urandom);
      d = 8'($urandom);
      e = 8'($urandom);
      p6_ext <= d;
      wr(IDX_P6_LATCH, a);
      wr(IDX_P6_DIR, b);
      wr(IDX_P6_INEN, c);
      v = (b & a) | (~b & c & d);
      v[e[2:0]] = e[3];
      wr(IDX_P6_BITOP, {4'h0, e[3:0]});
      wr(IDX_P6_DIR, 8'hff);
      rd(IDX_P6_LATCH, v);
    end
    apb(1'b0, 14'h0100, 32'h0, {1'b1, 32'h0});
    wr(IDX_P3_LATCH, 8'hff);
    repeat (2) @(posedge mclk_i);
    print_verdict();
  end
endmodule // mfp_port_group_tb_top
